// file: verilog/cfe_defs.svh
`ifndef CFE_DEFS_SVH
`define CFE_DEFS_SVH
// ==========================================
// Register map and flag positions
`define CFE_FLAGS_ADDR    8'hE7
`define CFE_CTRL_ADDR     8'hE8
`define CFE_FLAGS_RESET   8'h00
`define CFE_BIT_C         7
`define CFE_BIT_Z         6
`define CFE_BIT_S         5
`define CFE_BIT_V         4
`define CFE_BIT_D         3
`define CFE_BIT_H         2
`define CFE_BIT_USER      1
`define CFE_BIT_SPACE     0
`define CFE_PTR_RESET     8'h00
`endif

// file: verilog/cfe_pkg.sv
package cfe_pkg;
    // ==========================================
    // Operations presented to the flag unit
    typedef enum logic [4:0] {
        CFE_OP_NONE, CFE_OP_ALU, CFE_OP_COND_JUMP, CFE_OP_DIV, CFE_OP_STEPPED_WORD_DIVIDE,
        CFE_OP_CPJF, CFE_OP_CPJT, CFE_OP_BYTE_DECREMENT_LOOP, CFE_OP_WORD_DECREMENT_LOOP, CFE_OP_BIT_TEST_BRANCH_CLEAR,
        CFE_OP_BIT_TEST_BRANCH_SET, CFE_OP_WFI, CFE_OP_HALT, CFE_OP_SRP, CFE_OP_LOWER_REGISTER_POINTER_SET,
        CFE_OP_UPPER_REGISTER_POINTER_SET, CFE_OP_SPM, CFE_OP_SDM, CFE_OP_INTERRUPT_RETURN
    } cfe_op_t;
    // Condition codes
    typedef enum logic [4:0] {
        CFE_CC_F, CFE_CC_T, CFE_CC_C, CFE_CC_NC, CFE_CC_Z, CFE_CC_NZ,
        CFE_CC_PL, CFE_CC_MI, CFE_CC_OV, CFE_CC_NOV, CFE_CC_EQ, CFE_CC_NE,
        CFE_CC_SNB, CFE_CC_SB, CFE_CC_SA, CFE_CC_SNA,
        CFE_CC_UNB, CFE_CC_UB, CFE_CC_UA, CFE_CC_UNA
    } cfe_cc_t;
    // Core run state
    typedef enum logic [1:0] {CFE_RUN, CFE_WAIT, CFE_DMA, CFE_HALTED} cfe_run_t;
    // One instruction request
    typedef struct packed {
        logic        valid;      // Request present
        cfe_op_t     op;         // Operation
        cfe_cc_t     cc;         // Condition code
        logic [7:0]  a;          // First operand
        logic [7:0]  b;          // Second operand / bit number
        logic [15:0] word;       // Word operand
        logic [7:0]  res_flags;  // Flags from outer ALU / saved byte
        logic [7:0]  res_mask;   // Which flags ALU updates
        logic        div_zero;   // Divide result zero
        logic        div_sign;   // Divide result sign
    } cfe_req_t;
    // One result
    typedef struct packed {
        logic        done;
        logic        branch;
        logic        postinc;
        logic [15:0] count;
    } cfe_res_t;
endpackage : cfe_pkg

// file: verilog/cfe_cond_eval.sv
`timescale 1ns/1ps
`include "cfe_defs.svh"
// ==========================================
// Condition code evaluator (combinational)
module cfe_cond_eval import cfe_pkg::*; (
    input  wire logic [7:0] flags,
    input  wire cfe_cc_t    cc,
    output logic            taken
);
    logic c, z, s, v;
    // Flag extraction
    always_comb begin
        c = flags[`CFE_BIT_C];
        z = flags[`CFE_BIT_Z];
        s = flags[`CFE_BIT_S];
        v = flags[`CFE_BIT_V];
        case (cc)
            CFE_CC_F:   taken = 1'b0;
            CFE_CC_T:   taken = 1'b1;
            CFE_CC_C:   taken = c;
            CFE_CC_NC:  taken = ~c;
            CFE_CC_Z,
            CFE_CC_EQ:  taken = z;
            CFE_CC_NZ,
            CFE_CC_NE:  taken = ~z;
            CFE_CC_PL:  taken = ~s;
            CFE_CC_MI:  taken = s;
            CFE_CC_OV:  taken = v;
            CFE_CC_NOV: taken = ~v;
            CFE_CC_SNB: taken = ~(s ^ v);
            CFE_CC_SB:  taken = s ^ v;
            CFE_CC_SA:  taken = ~(z | (s ^ v));
            CFE_CC_SNA: taken = z | (s ^ v);
            CFE_CC_UNB: taken = ~c;
            CFE_CC_UB:  taken = c;
            CFE_CC_UA:  taken = ~c & ~z;
            CFE_CC_UNA: taken = c | z;
            default:    taken = 1'b0;
        endcase
    end
endmodule : cfe_cond_eval

// file: verilog/cfe_reg_ptr.sv
`timescale 1ns/1ps
`include "cfe_defs.svh"
// ==========================================
// Working register pointer pair
module cfe_reg_ptr import cfe_pkg::*; (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       set_long,
    input  wire logic       set_low,
    input  wire logic       set_high,
    input  wire logic [7:0] value,
    output logic [7:0]      ptr_low,
    output logic [7:0]      ptr_high
);
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
    } cfe_ptr_t;
    cfe_ptr_t st_reg, st_next;
    // Next pointer state
    always_comb begin
        st_next = st_reg;
        if (set_long) begin
            // 16-register window: two adjacent 8-register groups
            st_next.lo = {value[7:4], 4'h0};
            st_next.hi = {value[7:4], 4'h8};
        end else begin
            if (set_low)  st_next.lo = {value[7:3], 3'h0};
            if (set_high) st_next.hi = {value[7:3], 3'h0};
        end
    end
    // State register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) st_reg <= '{lo: `CFE_PTR_RESET, hi: `CFE_PTR_RESET};
        else         st_reg <= st_next;
    end
    assign ptr_low  = st_reg.lo;
    assign ptr_high = st_reg.hi;
endmodule : cfe_reg_ptr

// file: verilog/cfe_flag_unit.sv
`timescale 1ns/1ps
`include "cfe_defs.svh"
// Overview of operation
// - Flags byte lives at register 231
// - Bit 1 user flag, software only
// - Bit 0 memory space, drives pin
// - Jumps test C Z S V; aliases
// - Signed conditions from S xor V
// - Unsigned not-below/below from carry
// - Unsigned above/not-above from C, Z
// - Divide sets C D; stepped undefined
// - Compare-jump-false, else postinc, flags kept
// - Compare-jump-true, else postinc, flags kept
// - Byte decrement loop, flags kept
// - Word decrement loop, flags kept
// - Bit test branch, flags kept
// - Wait for interrupt, serve DMA
// - Halt until reset, flags kept
// - Long pointer sets 16-register window
// - Split pointers set 8-register groups
module cfe_flag_unit import cfe_pkg::*; (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire cfe_req_t   req,
    input  wire logic       irq_pending,
    input  wire logic       dma_req,
    input  wire logic       dma_done,
    output cfe_res_t        res,
    output logic            mem_space,
    output logic [7:0]      flags_out,
    output cfe_run_t        run_state,
    output logic [7:0]      ptr_low,
    output logic [7:0]      ptr_high
);
    // ==========================================
    // State
    typedef struct packed {
        logic [7:0]  flags;    // Flag byte
        cfe_run_t    run;      // Run state
        cfe_res_t    res;      // Registered result
        logic [7:0]  rdata;    // Read data
        logic        space;    // Pin copy
    } cfe_state_t;
    cfe_state_t st_reg, st_next;
    logic       cond_ok;       // Condition code result
    logic [7:0] byte_dec;      // Decremented byte
    logic [15:0] word_dec;     // Decremented word
    logic       accept;        // Instruction accepted
    logic       ptr_long, ptr_lo, ptr_hi;

    // ==========================================
    // Helpers
    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction : merge

    cfe_cond_eval u_cond (
        .flags (st_reg.flags),
        .cc    (req.cc),
        .taken (cond_ok)
    );

    assign accept   = req.valid && (st_reg.run == CFE_RUN);
    assign ptr_long = accept && (req.op == CFE_OP_SRP);
    assign ptr_lo   = accept && (req.op == CFE_OP_LOWER_REGISTER_POINTER_SET);
    assign ptr_hi   = accept && (req.op == CFE_OP_UPPER_REGISTER_POINTER_SET);

    cfe_reg_ptr u_ptr (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .set_long (ptr_long),
        .set_low  (ptr_lo),
        .set_high (ptr_hi),
        .value    (req.a),
        .ptr_low  (ptr_low),
        .ptr_high (ptr_high)
    );

    // ==========================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.res = '0;
        st_next.rdata = 8'h00;
        byte_dec = req.a - 8'h01;
        word_dec = req.word - 16'h0001;
        // Register read, data next cycle
        if (reg_rd) begin
            if (reg_addr == `CFE_FLAGS_ADDR) st_next.rdata = st_reg.flags;
            else if (reg_addr == `CFE_CTRL_ADDR) st_next.rdata = {6'h00, st_reg.run};
        end
        // Run state sequencing
        case (st_reg.run)
            CFE_RUN: begin
                if (accept) begin
                    st_next.res.done = 1'b1;
                    case (req.op)
                        CFE_OP_ALU: begin
                            // Outer ALU result; user and space bits protected
                            st_next.flags = merge(st_reg.flags, req.res_flags,
                                                  req.res_mask & 8'hFC);
                        end
                        CFE_OP_COND_JUMP: st_next.res.branch = cond_ok;
                        CFE_OP_DIV: begin
                            st_next.flags[`CFE_BIT_C] = 1'b1;
                            st_next.flags[`CFE_BIT_D] = 1'b1;
                            st_next.flags[`CFE_BIT_Z] = req.div_zero;
                            st_next.flags[`CFE_BIT_S] = req.div_sign;
                        end
                        CFE_OP_STEPPED_WORD_DIVIDE: begin
                            // Undefined flags: take what the divider leaves
                            st_next.flags = merge(st_reg.flags, req.res_flags,
                                                  8'hFC);
                        end
                        CFE_OP_CPJF: begin
                            st_next.res.branch  = (req.a != req.b);
                            st_next.res.postinc = (req.a == req.b);
                        end
                        CFE_OP_CPJT: begin
                            st_next.res.branch  = (req.a == req.b);
                            st_next.res.postinc = (req.a != req.b);
                        end
                        CFE_OP_BYTE_DECREMENT_LOOP: begin
                            st_next.res.count  = {8'h00, byte_dec};
                            st_next.res.branch = (byte_dec != 8'h00);
                        end
                        CFE_OP_WORD_DECREMENT_LOOP: begin
                            st_next.res.count  = word_dec;
                            st_next.res.branch = (word_dec != 16'h0000);
                        end
                        CFE_OP_BIT_TEST_BRANCH_CLEAR: st_next.res.branch = ~req.a[req.b[2:0]];
                        CFE_OP_BIT_TEST_BRANCH_SET: st_next.res.branch = req.a[req.b[2:0]];
                        CFE_OP_WFI:  st_next.run = CFE_WAIT;
                        CFE_OP_HALT: st_next.run = CFE_HALTED;
                        CFE_OP_SPM:  st_next.flags[`CFE_BIT_SPACE] = 1'b1;
                        CFE_OP_SDM:  st_next.flags[`CFE_BIT_SPACE] = 1'b0;
                        CFE_OP_INTERRUPT_RETURN: st_next.flags = req.res_flags;
                        default: ;
                    endcase
                end
            end
            CFE_WAIT: begin
                // Interrupt wins over DMA
                if (irq_pending)  st_next.run = CFE_RUN;
                else if (dma_req) st_next.run = CFE_DMA;
            end
            CFE_DMA: if (dma_done) st_next.run = CFE_WAIT;
            CFE_HALTED: st_next.run = CFE_HALTED;
            default: st_next.run = CFE_RUN;
        endcase
        // Software write of flag byte wins last
        if (reg_wr && reg_addr == `CFE_FLAGS_ADDR) st_next.flags = reg_wdata;
        st_next.space = st_next.flags[`CFE_BIT_SPACE];
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg       <= '0;
            st_reg.flags <= `CFE_FLAGS_RESET;
            st_reg.run   <= CFE_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign res       = st_reg.res;
    assign mem_space = st_reg.space;
    assign flags_out = st_reg.flags;
    assign run_state = st_reg.run;

    // ==========================================
    // Checks
    chk_halt_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
        run_state == CFE_HALTED |=> run_state == CFE_HALTED)
        else $error("halt left before reset");
    chk_pin_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
        mem_space == flags_out[`CFE_BIT_SPACE])
        else $error("memory space pin mismatch");
    chk_div_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
        accept && req.op == CFE_OP_DIV && !reg_wr |=> flags_out[`CFE_BIT_C]
        && flags_out[`CFE_BIT_D])
        else $error("divide carry or decimal not set");
    chk_cpj_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
        accept && (req.op inside {CFE_OP_CPJF, CFE_OP_CPJT, CFE_OP_BYTE_DECREMENT_LOOP, CFE_OP_WORD_DECREMENT_LOOP,
        CFE_OP_BIT_TEST_BRANCH_CLEAR, CFE_OP_BIT_TEST_BRANCH_SET, CFE_OP_SRP, CFE_OP_LOWER_REGISTER_POINTER_SET, CFE_OP_UPPER_REGISTER_POINTER_SET}) && !reg_wr
        |=> $stable(flags_out))
        else $error("flags changed by flag-neutral op");
    chk_cpjt_branch: assert property (@(posedge clk_sys) disable iff (sys_rst)
        accept && req.op == CFE_OP_CPJT |=> res.branch == $past(req.a == req.b)
        && res.postinc == !res.branch)
        else $error("compare jump true wrong");
    chk_byte_decrement_loop_branch: assert property (@(posedge clk_sys) disable iff (sys_rst)
        accept && req.op == CFE_OP_BYTE_DECREMENT_LOOP && req.a == 8'h01 |=> !res.branch
        && res.count == 16'h0000)
        else $error("byte loop branched on zero");
    chk_wfi_enter: assert property (@(posedge clk_sys) disable iff (sys_rst)
        accept && req.op == CFE_OP_WFI |=> run_state == CFE_WAIT)
        else $error("wait state not entered");
    chk_dma_return: assert property (@(posedge clk_sys) disable iff (sys_rst)
        run_state == CFE_DMA && dma_done |=> run_state == CFE_WAIT)
        else $error("no return to wait after dma");
    chk_user_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
        accept && req.op == CFE_OP_ALU && !reg_wr |=> $stable(flags_out[1:0]))
        else $error("user or space bit changed by alu");
endmodule : cfe_flag_unit

// file: test/cfe_flag_unit_tb_top.sv
`timescale 1ns/1ps
`include "cfe_defs.svh"
// ==========================================
// Self-checking bench for the flag unit
module cfe_flag_unit_tb_top import cfe_pkg::*;;
    // Expected instruction result
    typedef struct packed {
        logic        bc;   // Branch checked
        logic        br;   // Expected branch
        logic        pc;   // Post-increment checked
        logic        pi;   // Expected post-increment
        logic        cc;   // Count checked
        logic [15:0] cn;   // Expected count
    } cfe_note_t;
    logic        clk_sys     = 1'b0;
    logic        sys_rst     = 1'b1;
    logic [7:0]  reg_addr    = 8'h00;
    logic [7:0]  reg_wdata   = 8'h00;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    cfe_req_t    req         = '0;
    logic        irq_pending = 1'b0;
    logic        dma_req     = 1'b0;
    logic        dma_done    = 1'b0;
    logic [7:0]  reg_rdata;
    cfe_res_t    res;
    logic        mem_space;
    logic [7:0]  flags_out;
    cfe_run_t    run_state;
    logic [7:0]  ptr_low;
    logic [7:0]  ptr_high;
    int          err_count   = 0;
    int          n_checks    = 0;
    integer      seed        = 32'h9B5B520E;
    logic        rd_pend     = 1'b0;   // Read taken last edge
    logic [7:0]  rd_q[$];              // Expected read data
    cfe_note_t   res_q[$];             // Expected results
    cfe_note_t   nt;                   // Note under comparison
    logic [7:0]  fl;                   // Expected flag byte
    cfe_req_t    r;                    // Request being built
    logic [7:0]  a;                    // Random operand
    logic [7:0]  m;                    // Update mask
    logic        v;                    // Space bit seen
    logic [4:0]  c;                    // Condition code index
    // ==========================================
    // Clock and design
    always #5 clk_sys = ~clk_sys;
    cfe_flag_unit cfe_flag_unit_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .req(req), .irq_pending(irq_pending), .dma_req(dma_req), .dma_done(dma_done),
        .res(res), .mem_space(mem_space), .flags_out(flags_out), .run_state(run_state),
        .ptr_low(ptr_low), .ptr_high(ptr_high));
    // ==========================================
    // Compare, report, finish
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic tally_and_finish;
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Expected outcome of a condition code
    function automatic logic cc_exp(input logic [7:0] f, input cfe_cc_t k);
        logic y, z, s, o;
        y = f[`CFE_BIT_C];
        z = f[`CFE_BIT_Z];
        s = f[`CFE_BIT_S];
        o = f[`CFE_BIT_V];
        case (k)
            CFE_CC_F:             cc_exp = 1'b0;
            CFE_CC_T:             cc_exp = 1'b1;
            CFE_CC_C, CFE_CC_UB:  cc_exp = y;
            CFE_CC_NC, CFE_CC_UNB: cc_exp = !y;
            CFE_CC_Z, CFE_CC_EQ:  cc_exp = z;
            CFE_CC_NZ, CFE_CC_NE: cc_exp = !z;
            CFE_CC_PL:            cc_exp = !s;
            CFE_CC_MI:            cc_exp = s;
            CFE_CC_OV:            cc_exp = o;
            CFE_CC_NOV:           cc_exp = !o;
            CFE_CC_SNB:           cc_exp = !(s ^ o);
            CFE_CC_SB:            cc_exp = s ^ o;
            CFE_CC_SA:            cc_exp = !(z | (s ^ o));
            CFE_CC_SNA:           cc_exp = z | (s ^ o);
            CFE_CC_UA:            cc_exp = !y && !z;
            default:              cc_exp = y | z;
        endcase
    endfunction : cc_exp
    // Request and note builders
    function automatic cfe_req_t mk(input cfe_op_t o, input logic [7:0] x, input logic [7:0] y);
        mk = '0;
        mk.valid = 1'b1;
        mk.op = o;
        mk.a = x;
        mk.b = y;
    endfunction : mk
    function automatic cfe_note_t nm(input logic [5:0] k, input logic [15:0] n);
        nm = {k[5:1], n};
    endfunction : nm
    // ==========================================
    // Bus master and instruction driver
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk_sys);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic issue(input cfe_req_t q, input cfe_note_t e, input logic tk, input logic kp);
        if (tk) res_q.push_back(e);
        @(posedge clk_sys);
        req <= q;
        @(posedge clk_sys);
        req <= '0;
        @(negedge clk_sys);
        if (kp) chk_val("flags kept", {8'h00, fl}, {8'h00, flags_out});
    endtask : issue
    task automatic st(input cfe_run_t e);
        chk_val("run_state", {14'h0, e}, {14'h0, run_state});
    endtask : st
    // ==========================================
    // Output watcher: read data and results
    always @(posedge clk_sys) rd_pend <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_pend) begin
            if (rd_q.size() == 0) chk_val("read queue", 16'h0, 16'h1);
            else chk_val("reg_rdata", {8'h00, rd_q.pop_front()}, {8'h00, reg_rdata});
        end
        if (res.done !== 1'b0) begin
            if (res_q.size() == 0) chk_val("unexpected done", 16'h0, 16'h1);
            else begin
                nt = res_q.pop_front();
                if (nt.bc) chk_val("branch", {15'h0, nt.br}, {15'h0, res.branch});
                if (nt.pc) chk_val("postinc", {15'h0, nt.pi}, {15'h0, res.postinc});
                if (nt.cc) chk_val("count", nt.cn, res.count);
            end
        end
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        tally_and_finish();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        fl = `CFE_FLAGS_RESET;
        @(negedge clk_sys);
        st(CFE_RUN);
        rd(`CFE_FLAGS_ADDR, `CFE_FLAGS_RESET);
        wr(`CFE_FLAGS_ADDR, 8'h02);
        wr(8'h10, 8'hFF);
        rd(`CFE_FLAGS_ADDR, 8'h02);
        rd(8'h10, 8'h00);
        rd(`CFE_CTRL_ADDR, 8'h00);
        // All codes back to back under random flags
        repeat (8) begin
            fl = 8'($random(seed)) & 8'hFE;
            wr(`CFE_FLAGS_ADDR, fl);
            for (c = 0; c < 20; c++) begin
                r = mk(CFE_OP_COND_JUMP, 8'h00, 8'h00);
                r.cc = cfe_cc_t'(c);
                res_q.push_back(nm({1'b1, cc_exp(fl, cfe_cc_t'(c)), 4'h0}, 16'h0));
                @(posedge clk_sys);
                req <= r;
            end
            @(posedge clk_sys);
            req <= '0;
            @(negedge clk_sys);
        end
        // Masked result flags keep bits 1:0
        repeat (4) begin
            r = mk(CFE_OP_ALU, 8'h00, 8'h00);
            r.res_flags = 8'($random(seed));
            r.res_mask = 8'($random(seed));
            m = r.res_mask & 8'hFC;
            fl = (fl & ~m) | (r.res_flags & m);
            issue(r, '0, 1'b1, 1'b1);
        end
        // Divides
        r = mk(CFE_OP_DIV, 8'h00, 8'h00);
        r.div_zero = 1'b1;
        r.div_sign = 1'b0;
        issue(r, '0, 1'b1, 1'b0);
        chk_val("div flags", {8'h00, (fl & 8'h03) | 8'hC8}, {8'h00, flags_out & 8'hEB});
        r = mk(CFE_OP_STEPPED_WORD_DIVIDE, 8'h00, 8'h00);
        r.res_flags = ~fl;
        issue(r, '0, 1'b1, 1'b0);
        chk_val("stepped_word_divide low bits", {14'h0, fl[1:0]}, {14'h0, flags_out[1:0]});
        wr(`CFE_FLAGS_ADDR, fl);
        // Loops, compares, bit tests
        a = 8'h01 | 8'($random(seed));
        issue(mk(CFE_OP_BYTE_DECREMENT_LOOP, 8'h02, 8'h00), nm(6'b110010, 16'h0001), 1'b1, 1'b1);
        issue(mk(CFE_OP_BYTE_DECREMENT_LOOP, 8'h01, 8'h00), nm(6'b100010, 16'h0000), 1'b1, 1'b1);
        issue(mk(CFE_OP_BYTE_DECREMENT_LOOP, a, 8'h00), nm({1'b1, a != 8'h01, 4'h2}, {8'h00, a - 8'h01}), 1'b1, 1'b1);
        r = mk(CFE_OP_WORD_DECREMENT_LOOP, 8'h00, 8'h00);
        r.word = 16'h0100;
        issue(r, nm(6'b110010, 16'h00FF), 1'b1, 1'b1);
        r.word = 16'h0001;
        issue(r, nm(6'b100010, 16'h0000), 1'b1, 1'b1);
        issue(mk(CFE_OP_CPJF, a, a), nm(6'b101100, 16'h0), 1'b1, 1'b1);
        issue(mk(CFE_OP_CPJF, a, ~a), nm(6'b111000, 16'h0), 1'b1, 1'b1);
        issue(mk(CFE_OP_CPJT, a, a), nm(6'b111000, 16'h0), 1'b1, 1'b1);
        issue(mk(CFE_OP_CPJT, a, ~a), nm(6'b101100, 16'h0), 1'b1, 1'b1);
        for (c = 0; c < 8; c++) begin
            issue(mk(CFE_OP_BIT_TEST_BRANCH_CLEAR, a, {5'h0, c[2:0]}), nm({1'b1, !a[c[2:0]], 4'h0}, 16'h0), 1'b1, 1'b1);
            issue(mk(CFE_OP_BIT_TEST_BRANCH_SET, a, {5'h0, c[2:0]}), nm({1'b1, a[c[2:0]], 4'h0}, 16'h0), 1'b1, 1'b1);
        end
        // Register pointers
        issue(mk(CFE_OP_SRP, a, 8'h00), '0, 1'b1, 1'b1);
        chk_val("pointers long", {a[7:4], 4'h0, a[7:4], 4'h8}, {ptr_low, ptr_high});
        issue(mk(CFE_OP_LOWER_REGISTER_POINTER_SET, ~a, 8'h00), '0, 1'b1, 1'b1);
        chk_val("pointer low", {~a[7:3], 3'h0, a[7:4], 4'h8}, {ptr_low, ptr_high});
        issue(mk(CFE_OP_UPPER_REGISTER_POINTER_SET, a, 8'h00), '0, 1'b1, 1'b1);
        chk_val("pointer high", {~a[7:3], 3'h0, a[7:3], 3'h0}, {ptr_low, ptr_high});
        // Interrupt return and memory space select
        r = mk(CFE_OP_INTERRUPT_RETURN, 8'h00, 8'h00);
        r.res_flags = 8'($random(seed)) | 8'h01;
        fl = r.res_flags;
        issue(r, '0, 1'b1, 1'b1);
        chk_val("space pin", 16'h1, {15'h0, mem_space});
        issue(mk(CFE_OP_SPM, 8'h00, 8'h00), '0, 1'b1, 1'b0);
        v = mem_space;
        chk_val("space follows", {fl[7:1], v, 8'h0}, {flags_out, 8'h0});
        issue(mk(CFE_OP_SDM, 8'h00, 8'h00), '0, 1'b1, 1'b0);
        chk_val("space toggles", {fl[7:1], !v, 7'h0, !v}, {flags_out, 7'h0, mem_space});
        // Wait with DMA service
        issue(mk(CFE_OP_WFI, 8'h00, 8'h00), '0, 1'b1, 1'b0);
        st(CFE_WAIT);
        issue(mk(CFE_OP_BYTE_DECREMENT_LOOP, 8'h05, 8'h00), '0, 1'b0, 1'b0);
        @(posedge clk_sys);
        dma_req <= 1'b1;
        @(posedge clk_sys);
        dma_req <= 1'b0;
        @(negedge clk_sys);
        st(CFE_DMA);
        rd(`CFE_CTRL_ADDR, {6'h0, CFE_DMA});
        @(posedge clk_sys);
        dma_done <= 1'b1;
        @(posedge clk_sys);
        dma_done <= 1'b0;
        @(negedge clk_sys);
        st(CFE_WAIT);
        // Interrupt and DMA together: interrupt wins
        @(posedge clk_sys);
        irq_pending <= 1'b1;
        dma_req <= 1'b1;
        @(posedge clk_sys);
        irq_pending <= 1'b0;
        dma_req <= 1'b0;
        @(negedge clk_sys);
        st(CFE_RUN);
        // Halt until reset
        fl = flags_out;
        issue(mk(CFE_OP_HALT, 8'h00, 8'h00), '0, 1'b1, 1'b1);
        st(CFE_HALTED);
        @(posedge clk_sys);
        irq_pending <= 1'b1;
        issue(mk(CFE_OP_BYTE_DECREMENT_LOOP, 8'h05, 8'h00), '0, 1'b0, 1'b1);
        st(CFE_HALTED);
        @(posedge clk_sys);
        irq_pending <= 1'b0;
        sys_rst <= 1'b1;
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        st(CFE_RUN);
        chk_val("after reset", 16'h0, {flags_out, 7'h0, mem_space});
        chk_val("queues empty", 16'h0, 16'(res_q.size() + rd_q.size()));
        tally_and_finish();
    end
endmodule : cfe_flag_unit_tb_top
